// ==== logic/ext_irq_pkg.sv ====
// Constants, codes and types shared by the external interrupt input filter.
// Assumes one 100 MHz gear clock and a low-frequency clock sampled as a plain input.
package ext_irq_pkg;
	// ----------------------------------------------------------------
	// Register map, byte addresses on the AXI4-Lite slave
	// ----------------------------------------------------------------
	localparam int         ADDR_W         = 8;
	localparam logic [7:0] OFS_CTRL1      = 8'h00;
	localparam logic [7:0] OFS_CTRL2      = 8'h04;
	localparam logic [7:0] OFS_CTRL3      = 8'h08;
	localparam logic [7:0] OFS_CTRL4      = 8'h0C;
	localparam logic [7:0] OFS_POWER_GATE = 8'h10;
	localparam logic [7:0] OFS_SYS        = 8'h14;
	localparam logic [7:0] OFS_ENABLE     = 8'h18;
	localparam logic [7:0] OFS_LATCH      = 8'h1C;
	localparam logic [7:0] OFS_PIN_DIR    = 8'h20;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_IVL_LSB   = 0;
	localparam int CTRL_TRIG_LSB  = 2;
	localparam int CTRL_LEVEL_BIT = 4;
	localparam int GATE_BIT       = 0;
	localparam int SYS_MODE_LSB   = 0;
	localparam int SYS_MASTER_BIT = 2;
	// ----------------------------------------------------------------
	// Reset values and codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CTRL_FIELD_RST = 2'h0;
	localparam logic       GATE_RST       = 1'h0;
	localparam logic [1:0] MODE_RST       = 2'h0;
	localparam logic [5:0] SRC_BITS_RST   = 6'h00;
	localparam logic [5:0] SEL_MASK       = 6'h1E;
	localparam logic [1:0] TRIG_RISE      = 2'h0;
	localparam logic [1:0] TRIG_FALL      = 2'h1;
	localparam logic [1:0] TRIG_BOTH      = 2'h2;
	localparam logic [1:0] TRIG_HIGH      = 2'h3;
	localparam logic [1:0] IVL_DIV1       = 2'h0;
	localparam logic [1:0] IVL_DIV4       = 2'h1;
	localparam logic [1:0] IVL_DIV8       = 2'h2;
	localparam logic [1:0] IVL_DIV16      = 2'h3;
	localparam logic [1:0] MODE_FAST      = 2'h0;
	localparam logic [1:0] MODE_SLOW      = 2'h1;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         CLK_PERIOD_NS = 10;
	localparam logic [1:0] LF_DIV_LAST   = 2'h3;
	localparam logic [3:0] PRE_DIV4_LAST = 4'h3;
	localparam logic [3:0] PRE_DIV8_LAST = 4'h7;
	localparam logic [3:0] PRE_DIV16_LAST = 4'hF;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_FAST = 3'b001,
		OP_SLOW = 3'b010,
		OP_HALT = 3'b100
	} op_mode_e;
	typedef struct packed {
		logic [1:0] trig;
		logic [1:0] interval;
	} src_ctrl_s;
endpackage

// ==== logic/ext_irq_filter.sv ====
// One noise canceller: a gear-clock presample and two history samples.
// Assumes the sample strobe and sample count come from the parent.
`timescale 1ns/10ps
module ext_irq_filter (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic enable_in,
	input  wire logic sample_in,
	input  wire logic need_three_in,
	input  wire logic pin_in,
	output logic      level_out
);
	logic s0_r;
	logic h1_r;
	logic h2_r;
	logic level_r;
	logic agree;

	// ----------------------------------------------------------------
	// Sampling
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s0_r <= 1'b0;
		end else if (!enable_in) begin
			s0_r <= 1'b0;
		end else begin
			s0_r <= pin_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			h1_r <= 1'b0;
			h2_r <= 1'b0;
		end else if (!enable_in) begin
			h1_r <= 1'b0;
			h2_r <= 1'b0;
		end else if (sample_in) begin
			h1_r <= s0_r;
			h2_r <= h1_r;
		end
	end

	// Continuous noise faster than the interval still aliases through.
	assign agree = (s0_r == h1_r) && (!need_three_in || (h1_r == h2_r));

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			level_r <= 1'b0;
		end else if (!enable_in) begin
			level_r <= 1'b0;
		end else if (sample_in && agree) begin
			level_r <= s0_r;
		end
	end

	assign level_out = level_r;

	a_filter_agree: assert property (@(posedge clk_in) disable iff (rst_in)
		($changed(level_r) && $past(enable_in)) |->
		($past(s0_r) == level_r && $past(h1_r) == level_r &&
		 (!$past(need_three_in) || $past(h2_r) == level_r)))
		else $error("filter level changed without agreeing samples");
endmodule

// ==== logic/external_irq_input_filter.sv ====
// Six external interrupt inputs: noise cancellers, trigger detection,
// request latches and an AXI4-Lite register slave.
// Assumes pins and the low-frequency clock are synchronous to CLK_IN.
//
// Functional notes
// - Source zero requests on filtered falling edge only.
// - Fast mode source zero: two gear-clock samples agree.
// - Slow mode fixed sources: two quarter-rate samples.
// - Source five: filtered falling edge, fast filtering.
// - Sources one-four fast: three samples at interval.
// - Two-bit trigger: rise, fall, both, high.
// - Source four has the same trigger field.
// - Filtered level captured at every selectable request.
// - Presample, resample, accept three identical samples.
// - Interval field: divide by 1, 4, 8, 16.
// - Slow mode: quarter low-frequency rate, two samples.
// - Deep low-power modes halt sampling and requests.
// - Power gate bit zero stops the block.
// - Power gate resets to zero; software sets first.
// - Output-mode pin forces input path low.
// - Captured level reads zero after reset.
// - Control register upper three bits read zero.
`timescale 1ns/10ps
module external_irq_input_filter #(
	parameter int NUM_SRC = 6
) (
	input  wire logic                              CLK_IN,
	input  wire logic                              RST_IN,
	input  wire logic                              LOW_FREQ_CLOCK_IN,
	input  wire logic                              IRQ_PIN_ZERO_IN,
	input  wire logic                              IRQ_PIN_ONE_IN,
	input  wire logic                              IRQ_PIN_TWO_IN,
	input  wire logic                              IRQ_PIN_THREE_IN,
	input  wire logic                              IRQ_PIN_FOUR_IN,
	input  wire logic                              IRQ_PIN_FIVE_IN,
	input  wire logic [ext_irq_pkg::ADDR_W-1:0]    S_AXI_AWADDR_IN,
	input  wire logic                              S_AXI_AWVALID_IN,
	output logic                                   S_AXI_AWREADY_OUT,
	input  wire logic [31:0]                       S_AXI_WDATA_IN,
	input  wire logic [3:0]                        S_AXI_WSTRB_IN,
	input  wire logic                              S_AXI_WVALID_IN,
	output logic                                   S_AXI_WREADY_OUT,
	output logic [1:0]                             S_AXI_BRESP_OUT,
	output logic                                   S_AXI_BVALID_OUT,
	input  wire logic                              S_AXI_BREADY_IN,
	input  wire logic [ext_irq_pkg::ADDR_W-1:0]    S_AXI_ARADDR_IN,
	input  wire logic                              S_AXI_ARVALID_IN,
	output logic                                   S_AXI_ARREADY_OUT,
	output logic [31:0]                            S_AXI_RDATA_OUT,
	output logic [1:0]                             S_AXI_RRESP_OUT,
	output logic                                   S_AXI_RVALID_OUT,
	input  wire logic                              S_AXI_RREADY_IN,
	output logic [5:0]                             IRQ_OUT
);
	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (NUM_SRC != 6) begin : g_bad_num
		$error("NUM_SRC must be 6");
	end

	ext_irq_pkg::src_ctrl_s   ctrl_r [6];
	logic [5:0]               cap_r;
	logic                     gate_r;
	logic [1:0]               mode_r;
	logic                     master_r;
	logic [5:0]               en_r;
	logic [5:0]               latch_r;
	logic [5:0]               dir_r;
	logic [5:0]               irq_r;
	logic [5:0]               pins;
	logic [5:0]               pin_eff;
	logic [5:0]               filt;
	logic [5:0]               prev_r;
	logic [5:0]               req;
	logic [5:0]               sample;
	logic [5:0]               need_three;
	logic [3:0]               pre_cnt_r;
	logic [3:0]               tick_div;
	logic                     lf_prev_r;
	logic [1:0]               lf_cnt_r;
	logic                     slow_tick;
	logic                     run;
	ext_irq_pkg::op_mode_e    op;
	logic                     aw_hold_r;
	logic                     w_hold_r;
	logic [ext_irq_pkg::ADDR_W-1:0] aw_addr_r;
	logic [7:0]               w_byte_r;
	logic                     w_lane_r;
	logic                     bvalid_r;
	logic [1:0]               bresp_r;
	logic                     rvalid_r;
	logic [1:0]               rresp_r;
	logic [31:0]              rdata_r;
	logic                     rd_ctrl_r;
	logic                     wr_fire;
	logic                     wr_ok;
	logic [7:0]               wr_ofs;
	logic [7:0]               rd_ofs;
	logic [31:0]              rd_data;
	logic                     rd_ok;
	logic [5:0]               clr_mask;
	logic [2:0]               wr_idx;
	logic [2:0]               rd_idx;

	// ----------------------------------------------------------------
	// Operating mode and sample strobes
	// ----------------------------------------------------------------
	always_comb begin
		case (mode_r)
			ext_irq_pkg::MODE_FAST: op = ext_irq_pkg::OP_FAST;
			ext_irq_pkg::MODE_SLOW: op = ext_irq_pkg::OP_SLOW;
			default:                op = ext_irq_pkg::OP_HALT;
		endcase
	end

	assign run = gate_r && (op != ext_irq_pkg::OP_HALT);

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pre_cnt_r <= 4'h0;
		end else begin
			pre_cnt_r <= pre_cnt_r + 4'h1;
		end
	end

	assign tick_div[0] = 1'b1;
	assign tick_div[1] = (pre_cnt_r[1:0] == ext_irq_pkg::PRE_DIV4_LAST[1:0]);
	assign tick_div[2] = (pre_cnt_r[2:0] == ext_irq_pkg::PRE_DIV8_LAST[2:0]);
	assign tick_div[3] = (pre_cnt_r == ext_irq_pkg::PRE_DIV16_LAST);

	// Low-frequency clock is only sampled, so it must run well under CLK_IN / 2.
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			lf_prev_r <= 1'b0;
			lf_cnt_r  <= 2'h0;
		end else begin
			lf_prev_r <= LOW_FREQ_CLOCK_IN;
			if (LOW_FREQ_CLOCK_IN && !lf_prev_r) begin
				lf_cnt_r <= lf_cnt_r + 2'h1;
			end
		end
	end

	assign slow_tick = LOW_FREQ_CLOCK_IN && !lf_prev_r &&
		(lf_cnt_r == ext_irq_pkg::LF_DIV_LAST);

	// ----------------------------------------------------------------
	// Filters and trigger detection
	// ----------------------------------------------------------------
	assign pins    = {IRQ_PIN_FIVE_IN, IRQ_PIN_FOUR_IN, IRQ_PIN_THREE_IN,
		IRQ_PIN_TWO_IN, IRQ_PIN_ONE_IN, IRQ_PIN_ZERO_IN};
	assign pin_eff = pins & ~dir_r;

	for (genvar i = 0; i < 6; i++) begin : g_src
		localparam bit SEL = ext_irq_pkg::SEL_MASK[i];
		logic [1:0] trig;
		logic       rise;
		logic       fall;

		assign need_three[i] = SEL && (op == ext_irq_pkg::OP_FAST);
		always_comb begin
			case (op)
				ext_irq_pkg::OP_FAST:
					sample[i] = gate_r && (SEL ? tick_div[ctrl_r[i].interval] : 1'b1);
				ext_irq_pkg::OP_SLOW:
					sample[i] = gate_r && slow_tick;
				default:
					sample[i] = 1'b0;
			endcase
		end

		ext_irq_filter u_filter (
			.clk_in        (CLK_IN),
			.rst_in        (RST_IN),
			.enable_in     (gate_r),
			.sample_in     (sample[i]),
			.need_three_in (need_three[i]),
			.pin_in        (pin_eff[i]),
			.level_out     (filt[i])
		);

		assign trig = SEL ? ctrl_r[i].trig : ext_irq_pkg::TRIG_FALL;
		assign rise = filt[i] && !prev_r[i];
		assign fall = !filt[i] && prev_r[i];
		always_comb begin
			case (trig)
				ext_irq_pkg::TRIG_RISE: req[i] = run && rise;
				ext_irq_pkg::TRIG_FALL: req[i] = run && fall;
				ext_irq_pkg::TRIG_BOTH: req[i] = run && (rise || fall);
				ext_irq_pkg::TRIG_HIGH: req[i] = run && filt[i];
				default:                req[i] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			prev_r <= ext_irq_pkg::SRC_BITS_RST;
		end else begin
			prev_r <= filt;
		end
	end

	// ----------------------------------------------------------------
	// Request latches, level capture, CPU request lines
	// ----------------------------------------------------------------
	assign clr_mask = (wr_fire && wr_ofs == ext_irq_pkg::OFS_LATCH && w_lane_r) ?
		w_byte_r[5:0] : 6'h00;

	// A request in the cycle of a software clear survives the clear.
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			latch_r <= ext_irq_pkg::SRC_BITS_RST;
		end else begin
			latch_r <= (latch_r & ~clr_mask) | req;
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cap_r <= ext_irq_pkg::SRC_BITS_RST;
		end else begin
			cap_r <= ((cap_r & ~req) | (filt & req)) & ext_irq_pkg::SEL_MASK;
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			irq_r <= ext_irq_pkg::SRC_BITS_RST;
		end else begin
			irq_r <= latch_r & en_r & {6{master_r}};
		end
	end

	assign IRQ_OUT = irq_r;

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign S_AXI_AWREADY_OUT = !aw_hold_r && !bvalid_r;
	assign S_AXI_WREADY_OUT  = !w_hold_r && !bvalid_r;
	assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_ofs  = {aw_addr_r[7:2], 2'b00};
	assign wr_ok   = (wr_ofs <= ext_irq_pkg::OFS_PIN_DIR);
	// A three-bit slot index keeps control register four from wrapping onto slot zero.
	assign wr_idx  = {1'b0, wr_ofs[3:2]} + 3'h1;

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
			aw_hold_r <= 1'b1;
			aw_addr_r <= S_AXI_AWADDR_IN;
		end else if (wr_fire) begin
			aw_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			w_hold_r <= 1'b0;
			w_byte_r <= 8'h00;
			w_lane_r <= 1'b0;
		end else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
			w_hold_r <= 1'b1;
			w_byte_r <= S_AXI_WDATA_IN[7:0];
			w_lane_r <= S_AXI_WSTRB_IN[0];
		end else if (wr_fire) begin
			w_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			bvalid_r <= 1'b0;
			bresp_r  <= ext_irq_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_ok ? ext_irq_pkg::RESP_OKAY : ext_irq_pkg::RESP_SLVERR;
		end else if (S_AXI_BREADY_IN) begin
			bvalid_r <= 1'b0;
		end
	end

	assign S_AXI_BVALID_OUT = bvalid_r;
	assign S_AXI_BRESP_OUT  = bresp_r;

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			for (int k = 0; k < 6; k++) begin
				ctrl_r[k] <= '{trig: ext_irq_pkg::CTRL_FIELD_RST,
					interval: ext_irq_pkg::CTRL_FIELD_RST};
			end
		end else if (wr_fire && w_lane_r && wr_ofs <= ext_irq_pkg::OFS_CTRL4) begin
			ctrl_r[wr_idx] <= '{
				trig:     w_byte_r[ext_irq_pkg::CTRL_TRIG_LSB +: 2],
				interval: w_byte_r[ext_irq_pkg::CTRL_IVL_LSB +: 2]};
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			gate_r <= ext_irq_pkg::GATE_RST;
		end else if (wr_fire && w_lane_r && wr_ofs == ext_irq_pkg::OFS_POWER_GATE) begin
			gate_r <= w_byte_r[ext_irq_pkg::GATE_BIT];
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			mode_r   <= ext_irq_pkg::MODE_RST;
			master_r <= 1'b0;
		end else if (wr_fire && w_lane_r && wr_ofs == ext_irq_pkg::OFS_SYS) begin
			mode_r   <= w_byte_r[ext_irq_pkg::SYS_MODE_LSB +: 2];
			master_r <= w_byte_r[ext_irq_pkg::SYS_MASTER_BIT];
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			en_r  <= ext_irq_pkg::SRC_BITS_RST;
			dir_r <= ext_irq_pkg::SRC_BITS_RST;
		end else if (wr_fire && w_lane_r) begin
			if (wr_ofs == ext_irq_pkg::OFS_ENABLE) begin
				en_r <= w_byte_r[5:0];
			end
			if (wr_ofs == ext_irq_pkg::OFS_PIN_DIR) begin
				dir_r <= w_byte_r[5:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign rd_ofs = {S_AXI_ARADDR_IN[7:2], 2'b00};
	assign rd_idx = {1'b0, rd_ofs[3:2]} + 3'h1;

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (rd_ofs)
			ext_irq_pkg::OFS_CTRL1,
			ext_irq_pkg::OFS_CTRL2,
			ext_irq_pkg::OFS_CTRL3,
			ext_irq_pkg::OFS_CTRL4:
				rd_data = {27'h0, cap_r[rd_idx],
					ctrl_r[rd_idx].trig, ctrl_r[rd_idx].interval};
			ext_irq_pkg::OFS_POWER_GATE: rd_data = {31'h0, gate_r};
			ext_irq_pkg::OFS_SYS:        rd_data = {29'h0, master_r, mode_r};
			ext_irq_pkg::OFS_ENABLE:     rd_data = {26'h0, en_r};
			ext_irq_pkg::OFS_LATCH:      rd_data = {26'h0, latch_r};
			ext_irq_pkg::OFS_PIN_DIR:    rd_data = {26'h0, dir_r};
			default:                     rd_ok   = 1'b0;
		endcase
	end

	assign S_AXI_ARREADY_OUT = !rvalid_r;

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= ext_irq_pkg::RESP_OKAY;
			rd_ctrl_r <= 1'b0;
		end else if (S_AXI_ARVALID_IN && !rvalid_r) begin
			rvalid_r  <= 1'b1;
			rdata_r   <= rd_data;
			rresp_r   <= rd_ok ? ext_irq_pkg::RESP_OKAY : ext_irq_pkg::RESP_SLVERR;
			rd_ctrl_r <= (rd_ofs <= ext_irq_pkg::OFS_CTRL4);
		end else if (S_AXI_RREADY_IN) begin
			rvalid_r <= 1'b0;
		end
	end

	assign S_AXI_RVALID_OUT = rvalid_r;
	assign S_AXI_RDATA_OUT  = rdata_r;
	assign S_AXI_RRESP_OUT  = rresp_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_src0_fall_latch: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		($fell(filt[0]) && run) |=> latch_r[0])
		else $error("source zero falling edge not latched");

	a_src5_fall_latch: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		($fell(filt[5]) && run) |=> latch_r[5])
		else $error("source five falling edge not latched");

	a_src0_no_rise: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		($rose(filt[0]) && !latch_r[0]) |=> !latch_r[0])
		else $error("source zero latched on a rising edge");

	a_src4_high_level: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		(ctrl_r[4].trig == ext_irq_pkg::TRIG_HIGH && filt[4] && run) |=> latch_r[4])
		else $error("source four high level not latched");

	a_level_capture: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		((req & ext_irq_pkg::SEL_MASK) != 6'h00) |=>
		(((cap_r ^ $past(filt)) & $past(req) & ext_irq_pkg::SEL_MASK) == 6'h00))
		else $error("captured level differs from filtered level");

	a_div16_spacing: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		tick_div[3] |=> (!tick_div[3]) [*8])
		else $error("divide-by-16 strobe too frequent");

	a_halt_freeze: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		(op == ext_irq_pkg::OP_HALT && $past(op == ext_irq_pkg::OP_HALT) &&
		 gate_r && $past(gate_r)) |-> ($stable(filt) && req == 6'h00))
		else $error("filter moved while halted");

	a_gate_off_clear: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!gate_r |=> (filt == 6'h00 && req == 6'h00))
		else $error("gated block still active");

	a_gate_by_write: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$rose(gate_r) |-> $past(wr_fire))
		else $error("power gate set without a write");

	a_ctrl_upper_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		(rvalid_r && rd_ctrl_r) |-> (rdata_r[31:5] == 27'h0))
		else $error("control register upper bits not zero");

	a_master_gates: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		(!master_r) [*2] |-> (irq_r == 6'h00))
		else $error("request reached CPU without master enable");
endmodule

// ==== verification/ext_pin_source.sv ====
// Behavioural model of the six external pin drivers and the low-frequency clock.
// Assumes drive is called just after a rising CLK edge.
`timescale 1ns/10ps
module ext_pin_source (
	input  wire logic       clk_in,
	output logic [5:0]      pins_out,
	output logic            lf_clock_out
);
	logic [2:0] div_r;
	// Fixed sources idle high, selectable ones idle low.
	initial pins_out = 6'h21;
	initial lf_clock_out = 1'h0;
	initial div_r = 3'h0;
	// The low-frequency clock runs free at CLK/16, well under the CLK/2 limit.
	always @(posedge clk_in) begin
		div_r <= div_r + 3'h1;
		if (div_r == 3'h7) begin
			lf_clock_out <= ~lf_clock_out;
		end
	end
	// A level is held until the next call, as a real driver would hold it.
	task automatic drive(input int i, input logic v);
		pins_out[i] <= v;
	endtask
endmodule

// ==== verification/tb_external_irq_input_filter.sv ====
// Self-checking bench for the external interrupt input filter.
// Assumes an AXI4-Lite slave of fixed short latency and a 100 MHz CLK_IN.
`timescale 1ns/10ps
module tb_external_irq_input_filter;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
	logic        awr, wrd, bv, arr, rv, lfc;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdt;
	logic [1:0]  br, rr;
	logic [5:0]  pins, irq;
	int          num_errors = 0, comparisons = 0;
	ext_pin_source src (.clk_in(clk), .pins_out(pins), .lf_clock_out(lfc));
	external_irq_input_filter uut (
		.CLK_IN(clk), .RST_IN(rst), .LOW_FREQ_CLOCK_IN(lfc),
		.IRQ_PIN_ZERO_IN(pins[0]), .IRQ_PIN_ONE_IN(pins[1]), .IRQ_PIN_TWO_IN(pins[2]),
		.IRQ_PIN_THREE_IN(pins[3]), .IRQ_PIN_FOUR_IN(pins[4]), .IRQ_PIN_FIVE_IN(pins[5]),
		.S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
		.S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
		.S_AXI_BREADY_IN(bre), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
		.S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdt), .S_AXI_RRESP_OUT(rr),
		.S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rre), .IRQ_OUT(irq)
	);
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic timeout(input int n);
		if (n >= 900) begin
			num_errors++;
			final_report();
		end
	endtask
	// Ready is sampled mid-cycle so the decision never races the clock edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
			input logic [1:0] e = ext_irq_pkg::RESP_OKAY);
		int n;
		logic ad, wdn, bd;
		logic [1:0] rs;
		@(posedge clk);
		n = 0;
		ad = 1'h0;
		wdn = 1'h0;
		bd = 1'h0;
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'h1;
		wv <= 1'h1;
		bre <= 1'h1;
		while (!bd && n < 900) begin
			@(negedge clk);
			bd = bv;
			rs = br;
			ad = ad | (awv & awr);
			wdn = wdn | (wv & wrd);
			@(posedge clk);
			awv <= !ad;
			wv <= !wdn;
			bre <= !bd;
			n++;
		end
		timeout(n);
		chk("bresp", e, {30'h0, rs});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
			input logic [1:0] er = ext_irq_pkg::RESP_OKAY);
		int n;
		logic ad, dn;
		logic [31:0] d;
		logic [1:0] rs;
		@(posedge clk);
		n = 0;
		ad = 1'h0;
		dn = 1'h0;
		ara <= a;
		arv <= 1'h1;
		rre <= 1'h1;
		while (!dn && n < 900) begin
			@(negedge clk);
			dn = rv;
			d = rdt;
			rs = rr;
			ad = ad | (arv & arr);
			@(posedge clk);
			arv <= !ad;
			rre <= !dn;
			n++;
		end
		timeout(n);
		chk("rdata", {24'h0, e}, d);
		chk("rresp", {30'h0, er}, {30'h0, rs});
	endtask
	task automatic irq_chk(input int s, input logic e);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (irq[s] !== 1'h1 && n < 700);
		chk("irq", {31'h0, e}, {31'h0, irq[s]});
		@(posedge clk);
	endtask
	task automatic pulse_chk(input int s, input logic a, input int len, input logic e);
		src.drive(s, a);
		repeat (len) @(posedge clk);
		src.drive(s, !a);
		irq_chk(s, e);
	endtask
	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		int t, iv;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rd(ext_irq_pkg::OFS_CTRL1, 8'h00);
		rd(ext_irq_pkg::OFS_POWER_GATE, 8'h00);
		rd(8'h24, 8'h00, ext_irq_pkg::RESP_SLVERR);
		wr(8'h24, 8'h00, ext_irq_pkg::RESP_SLVERR);
		wr(ext_irq_pkg::OFS_POWER_GATE, 8'h01);
		wr(ext_irq_pkg::OFS_CTRL1, 8'hFF);
		rd(ext_irq_pkg::OFS_CTRL1, 8'h0F);
		wr(ext_irq_pkg::OFS_SYS, 8'h04);
		wr(ext_irq_pkg::OFS_ENABLE, 8'h3F);
		wr(ext_irq_pkg::OFS_LATCH, 8'h3F);
		for (int s = 0; s < 6; s += 5) begin
			pulse_chk(s, 1'h0, 1, 1'h0);
			pulse_chk(s, 1'h0, 2, 1'h1);
			wr(ext_irq_pkg::OFS_LATCH, 8'h3F);
		end
		// Source n takes trigger code n-1 and the same interval code.
		for (int s = 1; s < 5; s++) begin
			t = s - 1;
			iv = (t == 0) ? 1 : (2 << t);
			wr(ext_irq_pkg::OFS_CTRL1 + 8'(4 * t), 8'(5 * t));
			wr(ext_irq_pkg::OFS_LATCH, 8'h3F);
			pulse_chk(s, 1'h1, 2 * iv - 1, 1'h0);
			pulse_chk(s, 1'h1, 4 * iv + 4, 1'h1);
			repeat (4 * iv + 8) @(posedge clk);
			rd(ext_irq_pkg::OFS_CTRL1 + 8'(4 * t), 8'(5 * t + ((t % 3 == 0) ? 16 : 0)));
		end
		wr(ext_irq_pkg::OFS_LATCH, 8'h3F);
		wr(ext_irq_pkg::OFS_SYS, 8'h00);
		pulse_chk(0, 1'h0, 2, 1'h0);
		rd(ext_irq_pkg::OFS_LATCH, 8'h01);
		wr(ext_irq_pkg::OFS_SYS, 8'h04);
		irq_chk(0, 1'h1);
		wr(ext_irq_pkg::OFS_LATCH, 8'h3F);
		wr(ext_irq_pkg::OFS_PIN_DIR, 8'h20);
		irq_chk(5, 1'h1);
		wr(ext_irq_pkg::OFS_PIN_DIR, 8'h00);
		wr(ext_irq_pkg::OFS_LATCH, 8'h3F);
		wr(ext_irq_pkg::OFS_SYS, 8'h06);
		pulse_chk(0, 1'h0, 8, 1'h0);
		wr(ext_irq_pkg::OFS_ENABLE, 8'h00);
		wr(ext_irq_pkg::OFS_SYS, 8'h04);
		wr(ext_irq_pkg::OFS_POWER_GATE, 8'h00);
		wr(ext_irq_pkg::OFS_ENABLE, 8'h3F);
		wr(ext_irq_pkg::OFS_LATCH, 8'h3F);
		pulse_chk(0, 1'h0, 8, 1'h0);
		wr(ext_irq_pkg::OFS_ENABLE, 8'h00);
		wr(ext_irq_pkg::OFS_POWER_GATE, 8'h01);
		wr(ext_irq_pkg::OFS_SYS, 8'h05);
		repeat (200) @(posedge clk);
		wr(ext_irq_pkg::OFS_LATCH, 8'h3F);
		wr(ext_irq_pkg::OFS_ENABLE, 8'h3F);
		pulse_chk(0, 1'h0, 40, 1'h0);
		pulse_chk(0, 1'h0, 200, 1'h1);
		final_report();
	end
endmodule
